/* design/srad_scratchpad.sv */
// Function
// RULE_01 - Program and data spaces separate, 64KB each
// RULE_02 - No path writes program memory
// RULE_03 - Data space only by external data move
// RULE_04 - On-chip range internal, rest external bus
// RULE_05 - Software sets on-chip program limit
// RULE_06 - Direct 00h-7Fh reaches lower scratchpad
// RULE_07 - Direct 80h-FFh reaches function registers
// RULE_08 - Indirect reaches full scratchpad 00h-FFh
// RULE_09 - Bytes 20h-2Fh give 128 bits
// RULE_10 - Function registers ending 0/8 bit-addressable
// RULE_11 - Bit versus byte from instruction type
// RULE_12 - Four banks of eight working registers
// RULE_13 - Bank chosen by status word bits
// RULE_14 - Stack pointer at 81h resets 07h
// RULE_15 - Push pre-increments, pop post-decrements pointer
// RULE_16 - Call and interrupt save return address
// RULE_17 - Working register access in one cycle
// RULE_18 - Bit 00h is LSB of 20h
module srad_scratchpad
  import srad_pkg::*;
#(
  parameter int RAM_DEPTH = 256
) (
  // Clock and reset
  input  wire logic            sys_clk_i,
  input  wire logic            nrst_i,
  // Register access from the core
  input  wire srad_req_t       req_i,
  output srad_rsp_t            rsp_o,
  // Return address save on call or interrupt entry
  input  wire logic            call_i,
  input  wire logic [15:0]     ret_addr_i,
  // Memory access from the core
  input  wire srad_mem_req_t   mem_req_i,
  input  wire logic            onchip_en_i,
  input  wire logic            limit_wr_i,
  input  wire logic [15:0]     limit_wdata_i,
  output srad_mem_route_t      mem_route_o,
  // Visible state
  output logic [7:0]           stack_top_pointer_o,
  output logic [7:0]           processor_status_flags_o,
  output logic [15:0]          onchip_program_limit_o
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] bit_byte(input logic [7:0] baddr); // see RULE_18
    bit_byte = baddr[7] ? {baddr[7:3], 3'b000} : (BIT_AREA_BASE + {4'h0, baddr[6:3]}); // see RULE_09
  endfunction : bit_byte

  function automatic logic [7:0] set_bit(input logic [7:0] v, input logic [2:0] pos, input logic b);
    logic [7:0] r;
    r      = v;
    r[pos] = b;
    set_bit = r;
  endfunction : set_bit

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0]  ram_reg [RAM_DEPTH];
  logic [7:0]  stack_top_pointer_reg;
  logic [7:0]  processor_status_flags_reg;
  logic [15:0] onchip_program_limit_reg;
  logic        call_hi_pending_reg;
  logic [7:0]  call_hi_reg;
  srad_rsp_t   rsp_reg;

  // ----------------------------------------------------------------
  // Address resolution
  // ----------------------------------------------------------------
  wire logic [1:0] bank_sel   = processor_status_flags_reg[BANK_SEL_MSB:BANK_SEL_LSB]; // see RULE_13
  wire logic [7:0] work_addr  = {3'b000, bank_sel, req_i.addr[2:0]}; // see RULE_12
  wire logic       is_bit     = (req_i.op == SRAD_OP_BIT); // see RULE_11
  wire logic [7:0] bit_addr_b = bit_byte(req_i.addr);
  wire logic [2:0] bit_pos    = req_i.addr[2:0];
  wire logic [7:0] sp_inc     = stack_top_pointer_reg + 8'h01;

  // Direct with bit 7 set means function register, never upper RAM
  wire logic direct_fr = (req_i.op == SRAD_OP_DIRECT) && req_i.addr[7]; // see RULE_07
  // Bit area above 7Fh lands on a function register whose address ends in 0 or 8
  wire logic bit_fr    = is_bit && req_i.addr[7]; // see RULE_10
  wire logic to_fr     = direct_fr || bit_fr;

  logic [7:0] ram_addr;
  always_comb begin
    unique case (req_i.op)
      SRAD_OP_DIRECT:   ram_addr = {1'b0, req_i.addr[6:0]}; // see RULE_06
      SRAD_OP_INDIRECT: ram_addr = req_i.addr; // see RULE_08
      SRAD_OP_WORKING:  ram_addr = work_addr; // see RULE_17
      SRAD_OP_BIT:      ram_addr = bit_addr_b;
      SRAD_OP_PUSH:     ram_addr = sp_inc; // see RULE_15
      SRAD_OP_POP:      ram_addr = stack_top_pointer_reg;
      default:          ram_addr = 8'h00;
    endcase
  end

  // Function registers held by this block; others read zero
  logic [7:0] fr_rdata;
  always_comb begin
    unique case (is_bit ? bit_addr_b : req_i.addr)
      STACK_TOP_POINTER_ADDR:      fr_rdata = stack_top_pointer_reg;
      PROCESSOR_STATUS_FLAGS_ADDR: fr_rdata = processor_status_flags_reg;
      default:                     fr_rdata = 8'h00;
    endcase
  end

  wire logic [7:0] byte_rd   = to_fr ? fr_rdata : ram_reg[ram_addr];
  wire logic       active    = (req_i.op != SRAD_OP_NONE);
  wire logic       do_wr     = active && (req_i.wr || (req_i.op == SRAD_OP_PUSH));
  wire logic [7:0] wr_val    = is_bit ? set_bit(byte_rd, bit_pos, req_i.wbit) : req_i.wdata;
  wire logic [7:0] fr_target = is_bit ? bit_addr_b : req_i.addr;
  wire logic       wr_sp     = do_wr && to_fr && (fr_target == STACK_TOP_POINTER_ADDR); // see RULE_14
  wire logic       wr_psw    = do_wr && to_fr && (fr_target == PROCESSOR_STATUS_FLAGS_ADDR);
  wire logic       wr_ram    = do_wr && !to_fr && (req_i.op != SRAD_OP_POP);

  // Call stacks two bytes: low then high on the next cycle
  wire logic       call_go   = call_i && !call_hi_pending_reg; // see RULE_16
  wire logic [7:0] sp_next   = call_go || call_hi_pending_reg || (req_i.op == SRAD_OP_PUSH) ? sp_inc :
                               (req_i.op == SRAD_OP_POP) ? stack_top_pointer_reg - 8'h01 :
                               wr_sp ? wr_val : stack_top_pointer_reg;

  srad_rsp_t rsp_next;
  assign rsp_next = '{valid: active, rdata: byte_rd, rbit: byte_rd[bit_pos],
                      is_function_reg: to_fr};

  // ----------------------------------------------------------------
  // State update
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stack_top_pointer_reg      <= STACK_TOP_POINTER_RST; // see RULE_14
      processor_status_flags_reg <= PROCESSOR_STATUS_FLAGS_RST;
      onchip_program_limit_reg   <= ONCHIP_LIMIT_RST;
      call_hi_pending_reg        <= 1'b0;
      call_hi_reg                <= 8'h00;
      rsp_reg                    <= '0;
    end else begin
      stack_top_pointer_reg      <= sp_next; // see RULE_15
      processor_status_flags_reg <= wr_psw ? wr_val : processor_status_flags_reg;
      onchip_program_limit_reg   <= limit_wr_i ? limit_wdata_i : onchip_program_limit_reg; // see RULE_05
      call_hi_pending_reg        <= call_go;
      call_hi_reg                <= call_go ? ret_addr_i[15:8] : call_hi_reg;
      rsp_reg                    <= rsp_next;
    end
  end

  // RAM has no reset; a call owns the stack port for its two cycles
  always_ff @(posedge sys_clk_i) begin
    if (call_go || call_hi_pending_reg) begin
      ram_reg[sp_inc] <= call_go ? ret_addr_i[7:0] : call_hi_reg; // see RULE_16
    end else if (wr_ram) begin
      ram_reg[ram_addr] <= wr_val;
    end
  end

  // Data space only through the router; register ops never reach it
  srad_mem_router u_router ( // see RULE_03
    .sys_clk_i      (sys_clk_i),
    .nrst_i         (nrst_i),
    .mem_req_i      (mem_req_i),
    .onchip_en_i    (onchip_en_i),
    .onchip_limit_i (onchip_program_limit_reg),
    .route_o        (mem_route_o)
  );

  assign rsp_o                    = rsp_reg;
  assign stack_top_pointer_o      = stack_top_pointer_reg;
  assign processor_status_flags_o = processor_status_flags_reg;
  assign onchip_program_limit_o   = onchip_program_limit_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence push_seq;
    req_i.op == SRAD_OP_PUSH && !call_i && !call_hi_pending_reg;
  endsequence

  sp_reset_val_a: assert property (@(posedge sys_clk_i) // see RULE_14
    $rose(nrst_i) |-> stack_top_pointer_reg == STACK_TOP_POINTER_RST)
    else $error("stack pointer not at reset value");

  push_incr_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // see RULE_15
    push_seq |=> stack_top_pointer_reg == $past(stack_top_pointer_reg) + 8'h01)
    else $error("push did not increment pointer");

  pop_decr_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // see RULE_15
    req_i.op == SRAD_OP_POP && !call_i && !call_hi_pending_reg
      |=> stack_top_pointer_reg == $past(stack_top_pointer_reg) - 8'h01)
    else $error("pop did not decrement pointer");

  call_two_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // see RULE_16
    call_go |=> call_hi_pending_reg ##1 stack_top_pointer_reg == $past(stack_top_pointer_reg, 2) + 8'h02)
    else $error("call did not stack two bytes");

  direct_fr_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // see RULE_07
    req_i.op == SRAD_OP_DIRECT && req_i.addr[7] |=> rsp_o.is_function_reg)
    else $error("direct upper address hit RAM");

  direct_ram_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // see RULE_06
    req_i.op == SRAD_OP_DIRECT && !req_i.addr[7] |=> rsp_o.valid && !rsp_o.is_function_reg)
    else $error("direct lower address missed RAM");

  indirect_ram_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // see RULE_08
    req_i.op == SRAD_OP_INDIRECT |-> ram_addr == req_i.addr && !to_fr)
    else $error("indirect did not reach full RAM");

  bank_map_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // see RULE_12
    req_i.op == SRAD_OP_WORKING |-> ram_addr == {3'b000, processor_status_flags_reg[4:3], req_i.addr[2:0]})
    else $error("working register bank mapping wrong");

  bit_map_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // see RULE_18
    is_bit && !req_i.addr[7] |-> ram_addr == 8'h20 + {4'h0, req_i.addr[6:3]})
    else $error("bit address mapped to wrong byte");

  one_cycle_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // see RULE_17
    req_i.op == SRAD_OP_WORKING |=> rsp_o.valid)
    else $error("working register answer late");

endmodule : srad_scratchpad

/* design/srad_pkg.sv */
package srad_pkg;

  // ----------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------
  localparam logic [7:0]  STACK_TOP_POINTER_ADDR      = 8'h81;
  localparam logic [7:0]  PROCESSOR_STATUS_FLAGS_ADDR = 8'hd0;
  localparam logic [7:0]  STACK_TOP_POINTER_RST       = 8'h07;
  localparam logic [7:0]  PROCESSOR_STATUS_FLAGS_RST  = 8'h00;
  localparam logic [7:0]  BIT_AREA_BASE               = 8'h20;
  localparam logic [7:0]  BIT_AREA_LAST               = 8'h2f;
  localparam logic [7:0]  DIRECT_RAM_LAST             = 8'h7f;
  localparam int          BANK_SEL_LSB                = 3;
  localparam int          BANK_SEL_MSB                = 4;
  localparam logic [15:0] ONCHIP_LIMIT_RST            = 16'h3fff;

  // ----------------------------------------------------------------
  // Request encodings
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SRAD_OP_NONE,
    SRAD_OP_DIRECT,
    SRAD_OP_INDIRECT,
    SRAD_OP_WORKING,
    SRAD_OP_BIT,
    SRAD_OP_PUSH,
    SRAD_OP_POP
  } srad_op_t;

  typedef enum logic [1:0] {
    SRAD_MEM_FETCH,
    SRAD_MEM_TABLE_READ,
    SRAD_MEM_EXT_READ,
    SRAD_MEM_EXT_WRITE
  } srad_mem_kind_t;

  typedef struct packed {
    srad_op_t   op;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wbit;
  } srad_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] rdata;
    logic       rbit;
    logic       is_function_reg;
  } srad_rsp_t;

  typedef struct packed {
    logic           valid;
    srad_mem_kind_t kind;
    logic [15:0]    addr;
  } srad_mem_req_t;

  typedef struct packed {
    logic        valid;
    logic        is_program;
    logic        is_external;
    logic        is_write;
    logic [15:0] addr;
  } srad_mem_route_t;

endpackage : srad_pkg

/* design/srad_mem_router.sv */
module srad_mem_router
  import srad_pkg::*;
(
  // Clock and reset
  input  wire logic            sys_clk_i,
  input  wire logic            nrst_i,
  // Request and limit
  input  wire srad_mem_req_t   mem_req_i,
  input  wire logic            onchip_en_i,
  input  wire logic [15:0]     onchip_limit_i,
  // Routed access
  output srad_mem_route_t      route_o
);

  wire logic is_prog    = (mem_req_i.kind == SRAD_MEM_FETCH) ||
                          (mem_req_i.kind == SRAD_MEM_TABLE_READ);
  // Program side has no write kind at all
  wire logic is_wr      = (mem_req_i.kind == SRAD_MEM_EXT_WRITE); // see RULE_02
  wire logic above_lim  = mem_req_i.addr > onchip_limit_i;
  wire logic ext_sel    = !onchip_en_i || (is_prog && above_lim) || !is_prog; // see RULE_04

  srad_mem_route_t route_next;
  assign route_next = '{valid: mem_req_i.valid, is_program: is_prog, is_external: ext_sel,
                        is_write: is_wr, addr: mem_req_i.addr}; // see RULE_01

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      route_o <= '0;
    end else begin
      route_o <= route_next; // see RULE_05
    end
  end

  fetch_limit_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // see RULE_05
    mem_req_i.valid && onchip_en_i && is_prog && (mem_req_i.addr > onchip_limit_i)
      |=> route_o.is_external)
    else $error("fetch above limit not routed externally");

  prog_nowrite_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // see RULE_02
    route_o.is_program |-> !route_o.is_write)
    else $error("program space write routed");

endmodule : srad_mem_router

/* verif/srad_core_model.sv */
module srad_core_model
  import srad_pkg::*;
(
  // Clock
  input  wire logic      sys_clk_i,
  // Requests toward the block
  output srad_req_t      req_o,
  output logic           call_o,
  output logic [15:0]    ret_addr_o,
  output srad_mem_req_t  mem_req_o,
  output logic           limit_wr_o,
  output logic [15:0]    limit_wdata_o
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    req_o = '0;
    call_o = 1'b0;
    ret_addr_o = 16'h0000;
    mem_req_o = '0;
    limit_wr_o = 1'b0;
    limit_wdata_o = 16'h0000;
  end

  // Idle lines show the inverse so stale values never pass
  task reg_op(input srad_op_t op, input logic wr, input logic [7:0] a, input logic [7:0] d, input logic b);
    @(posedge sys_clk_i);
    req_o <= '{op, wr, a, d, b};
    @(posedge sys_clk_i);
    req_o <= '{SRAD_OP_NONE, 1'b0, ~a, ~d, ~b};
  endtask : reg_op

  // Third edge lets the high byte land
  task call_op(input logic [15:0] ra);
    @(posedge sys_clk_i);
    call_o <= 1'b1;
    ret_addr_o <= ra;
    @(posedge sys_clk_i);
    call_o <= 1'b0;
    ret_addr_o <= ~ra;
    @(posedge sys_clk_i);
  endtask : call_op

  task mem_op(input srad_mem_kind_t k, input logic [15:0] a);
    @(posedge sys_clk_i);
    mem_req_o <= '{1'b1, k, a};
    @(posedge sys_clk_i);
    mem_req_o <= '{1'b0, k, ~a};
  endtask : mem_op

  task limit_op(input logic [15:0] v);
    @(posedge sys_clk_i);
    limit_wr_o <= 1'b1;
    limit_wdata_o <= v;
    @(posedge sys_clk_i);
    limit_wr_o <= 1'b0;
    limit_wdata_o <= ~v;
  endtask : limit_op
endmodule : srad_core_model

/* verif/testbench.sv */
`define CHK(w, e, g) begin compares++; if ((g) !== (e)) begin fail_count++; $display("wrong value %s expected %h seen %h", w, e, g); end end

module testbench import srad_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  logic            sys_clk_i = 1'b0;
  logic            nrst_i = 1'b0;
  logic            onchip_en = 1'b1;
  srad_req_t       req;
  logic            call;
  logic [15:0]     ret_addr;
  srad_mem_req_t   mreq;
  logic            lwr;
  logic [15:0]     lwd;
  srad_rsp_t       rsp;
  srad_mem_route_t route;
  logic [7:0]      sp;
  logic [7:0]      processor_status_flags;
  logic [15:0]     lim;
  int              fail_count = 0;
  int              compares = 0;
  int              cycles = 0;
  logic [7:0]      a;
  logic [7:0]      d;
  logic [15:0]     m;
  srad_mem_kind_t  k;

  always #50 sys_clk_i = ~sys_clk_i;

  srad_core_model core_u (.sys_clk_i(sys_clk_i), .req_o(req), .call_o(call), .ret_addr_o(ret_addr),
    .mem_req_o(mreq), .limit_wr_o(lwr), .limit_wdata_o(lwd));

  srad_scratchpad dut_u (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .req_i(req), .rsp_o(rsp), .call_i(call),
    .ret_addr_i(ret_addr), .mem_req_i(mreq), .onchip_en_i(onchip_en), .limit_wr_i(lwr), .limit_wdata_i(lwd),
    .mem_route_o(route), .stack_top_pointer_o(sp), .processor_status_flags_o(processor_status_flags), .onchip_program_limit_o(lim));

  task complete_run;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run

  // Answer must stand right after the taking edge
  task acc(input srad_op_t op, input logic wr, input logic [7:0] ad, input logic [7:0] wd, input logic b);
    core_u.reg_op(op, wr, ad, wd, b);
    #1;
    `CHK("answer valid", 1'b1, rsp.valid)
  endtask : acc

  function automatic logic is_ext(srad_mem_kind_t kk, logic [15:0] ad, logic en, logic [15:0] l);
    return !en || kk == SRAD_MEM_EXT_READ || kk == SRAD_MEM_EXT_WRITE || ad > l;
  endfunction : is_ext

  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      complete_run();
    end
  end

  initial begin
    void'($urandom(6357));
    repeat (5) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    #1;
    `CHK("pointer", 8'h07, sp)
    `CHK("limit", 16'h3fff, lim)
    $display("test reset done");
    repeat (8) begin
      a = 8'($urandom_range(127));
      d = 8'($urandom);
      acc(SRAD_OP_DIRECT, 1'b1, a, d, 1'b0);
      acc(SRAD_OP_DIRECT, 1'b0, a, 8'h00, 1'b0);
      `CHK("low ram", {d, 1'b0}, {rsp.rdata, rsp.is_function_reg})
    end
    d = 8'($urandom);
    acc(SRAD_OP_INDIRECT, 1'b1, 8'hc3, d, 1'b0);
    acc(SRAD_OP_DIRECT, 1'b0, 8'hc3, 8'h00, 1'b0);
    `CHK("function reg", 9'h001, {rsp.rdata, rsp.is_function_reg})
    acc(SRAD_OP_INDIRECT, 1'b0, 8'hc3, 8'h00, 1'b0);
    `CHK("upper ram", d, rsp.rdata)
    $display("test byte access done");
    repeat (8) begin
      a = 8'($urandom_range(127));
      d[0] = 1'($urandom);
      acc(SRAD_OP_BIT, 1'b1, a, 8'h00, d[0]);
      acc(SRAD_OP_DIRECT, 1'b0, 8'h20 + {4'h0, a[6:3]}, 8'h00, 1'b0);
      `CHK("bit in byte", d[0], rsp.rdata[a[2:0]])
      acc(SRAD_OP_BIT, 1'b0, a, 8'h00, 1'b0);
      `CHK("bit read", d[0], rsp.rbit)
    end
    acc(SRAD_OP_DIRECT, 1'b1, 8'hd0, 8'h00, 1'b0);
    acc(SRAD_OP_BIT, 1'b1, 8'hd4, 8'h00, 1'b1);
    `CHK("status bit", 8'h10, processor_status_flags)
    $display("test bit access done");
    for (int bk = 0; bk < 4; bk++) begin
      a = 8'($urandom_range(7));
      d = 8'($urandom);
      acc(SRAD_OP_DIRECT, 1'b1, 8'hd0, {3'h0, 2'(bk), 3'h0}, 1'b0);
      acc(SRAD_OP_WORKING, 1'b1, a, d, 1'b0);
      acc(SRAD_OP_DIRECT, 1'b0, {3'h0, 2'(bk), a[2:0]}, 8'h00, 1'b0);
      `CHK("bank reg", d, rsp.rdata)
      `CHK("bank bits", 2'(bk), processor_status_flags[BANK_SEL_MSB:BANK_SEL_LSB])
    end
    $display("test banks done");
    acc(SRAD_OP_DIRECT, 1'b1, STACK_TOP_POINTER_ADDR, 8'hf0, 1'b0);
    `CHK("pointer write", 8'hf0, sp)
    d = 8'($urandom);
    acc(SRAD_OP_PUSH, 1'b1, 8'h00, d, 1'b0);
    `CHK("push pointer", 8'hf1, sp)
    acc(SRAD_OP_POP, 1'b0, 8'h00, 8'h00, 1'b0);
    `CHK("pop data", d, rsp.rdata)
    `CHK("pop pointer", 8'hf0, sp)
    m = 16'($urandom);
    core_u.call_op(m);
    #1;
    `CHK("call pointer", 8'hf2, sp)
    acc(SRAD_OP_INDIRECT, 1'b0, 8'hf1, 8'h00, 1'b0);
    `CHK("return low", m[7:0], rsp.rdata)
    acc(SRAD_OP_INDIRECT, 1'b0, 8'hf2, 8'h00, 1'b0);
    `CHK("return high", m[15:8], rsp.rdata)
    $display("test stack done");
    core_u.limit_op(16'h1000);
    #1;
    `CHK("new limit", 16'h1000, lim)
    for (int i = 0; i < 16; i++) begin
      k = srad_mem_kind_t'(i % 4);
      m = (i % 3 == 0) ? 16'h1000 : (i % 3 == 1) ? 16'h1001 : 16'($urandom);
      @(posedge sys_clk_i) onchip_en <= (i < 12);
      core_u.mem_op(k, m);
      #1;
      `CHK("route", {1'b1, k <= SRAD_MEM_TABLE_READ, is_ext(k, m, i < 12, 16'h1000), k == SRAD_MEM_EXT_WRITE, m}, route)
    end
    $display("test memory route done");
    complete_run();
  end
endmodule : testbench
